// file: logic/ssd_pkg.sv
// constants and types for the step/direction front end
package ssd_pkg;
  localparam int unsigned NUM_AXES      = 4;
  localparam int unsigned POS_W         = 32;
  localparam int unsigned CLK_HZ        = 20_000_000;
  // idle time before current reduction, in milliseconds
  localparam int unsigned IDLE_MIN_MS   = 500;
  localparam int unsigned IDLE_MAX_MS   = 700;
  // midpoint of the allowed window, rounded to whole cycles
  localparam int unsigned IDLE_CYCLES   = (CLK_HZ / 1000) * ((IDLE_MIN_MS + IDLE_MAX_MS) / 2);
  // over-temperature threshold window, degrees celsius
  localparam logic [7:0]  TEMP_MIN_C    = 8'h46;
  localparam logic [7:0]  TEMP_MAX_C    = 8'h55;
  localparam logic [7:0]  TEMP_LIMIT_RST = 8'h50;
  // register byte offsets
  localparam logic [7:0]  REG_SWITCH    = 8'h00;
  localparam logic [7:0]  REG_STATUS    = 8'h04;
  localparam logic [7:0]  REG_TLIMIT    = 8'h08;
  localparam logic [7:0]  REG_POS0      = 8'h10;
  // switch bank reset value: xyz current on, rest off
  localparam logic [7:0]  SWITCH_RST    = 8'h40;
  // field positions in the switch register
  localparam int unsigned SW_RES_LSB    = 0;
  localparam int unsigned SW_CCUR_LSB   = 4;
  localparam int unsigned SW_XYZCUR_BIT = 6;
  localparam int unsigned SW_AUX_BIT    = 7;
  // current codes, tenths of an ampere
  localparam logic [5:0]  CUR_1A4       = 6'h0e;
  localparam logic [5:0]  CUR_2A0       = 6'h14;
  localparam logic [5:0]  CUR_2A8       = 6'h1c;
  localparam logic [5:0]  CUR_3A5       = 6'h23;
  // microsteps per full step
  localparam logic [3:0]  USTEP_FINE    = 4'ha;
  localparam logic [3:0]  USTEP_COARSE  = 4'h5;
  typedef enum logic {SSD_AUX_PWM, SSD_AUX_BRAKE} ssd_aux_t;
endpackage

// file: logic/ssd_axis.sv
// one axis: step edge detection and position counter
`timescale 1ns/1ns
module ssd_axis #(
  parameter int unsigned POS_W = 32
) (
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic             stepSync,
  input  wire logic             dirSync,
  output logic                  stepEvent,
  output logic [POS_W-1:0]      position
);
  logic             stepPrev_q;
  logic             stepPrev_d;
  logic [POS_W-1:0] pos_q;
  logic [POS_W-1:0] pos_d;
  logic             event_q;
  logic             event_d;

  // rising edge only moves the axis, direction taken at the edge
  always_comb
  begin
    stepPrev_d = stepSync;
    event_d    = stepSync & ~stepPrev_q;
    pos_d      = pos_q;
    if (event_d)
    begin
      if (dirSync)
        pos_d = pos_q + POS_W'(1);
      else
        pos_d = pos_q - POS_W'(1);
    end
  end

  // registers
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      stepPrev_q <= 1'b0;
      pos_q      <= '0;
      event_q    <= 1'b0;
    end
    else
    begin
      stepPrev_q <= stepPrev_d;
      pos_q      <= pos_d;
      event_q    <= event_d;
    end
  end

  assign stepEvent = event_q;
  assign position  = pos_q;
endmodule

// file: logic/ssd_top.sv
// step/direction front end with switch bank and wishbone registers
// Functional notes
// - Each axis has a resolution switch: off gives 1/10 step, on gives 1/5, default off.
// - Two switches pick C motor current 1.4, 2.0, 2.8 or 3.5 A, default 1.4 A.
// - One switch sets X, Y and Z current to 2.8 A when off or 3.5 A when on, default on.
// - One switch makes the 24V output an oscillation PWM drive when off, default, or a brake.
// - A step is taken only on a rising edge of an axis step input.
// - Current drops after 0.5 to 0.7 s with no step on any axis.
// - Over-temperature response fires when sensed temperature passes a 70 to 85 C limit.
//
// Chosen here: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ns
module ssd_top #(
  parameter int unsigned IDLE_CYCLES = ssd_pkg::IDLE_CYCLES
) (
  input  wire logic                              core_clk,
  input  wire logic                              reset,
  input  wire logic [ssd_pkg::NUM_AXES-1:0]      stepIn,
  input  wire logic [ssd_pkg::NUM_AXES-1:0]      dirIn,
  input  wire logic [7:0]                        tempIn,
  input  wire logic                              wb_cyc_i,
  input  wire logic                              wb_stb_i,
  input  wire logic                              wb_we_i,
  input  wire logic [7:0]                        wb_adr_i,
  input  wire logic [3:0]                        wb_sel_i,
  input  wire logic [31:0]                       wb_dat_i,
  output logic [31:0]                            wb_dat_o,
  output logic                                   wb_ack_o,
  output logic [ssd_pkg::NUM_AXES*4-1:0]         ustepDiv,
  output logic [5:0]                             currentC,
  output logic [5:0]                             currentXyz,
  output logic                                   currentReduced,
  output logic                                   auxPwmMode,
  output logic                                   auxBrakeMode,
  output logic                                   overTemp
);
  localparam int unsigned N = ssd_pkg::NUM_AXES;
  localparam int unsigned W = ssd_pkg::POS_W;

  // input synchronisers, two stages each
  logic [N-1:0] stepMeta_q;
  logic [N-1:0] stepSync_q;
  logic [N-1:0] dirMeta_q;
  logic [N-1:0] dirSync_q;
  logic [7:0]   tempMeta_q;
  logic [7:0]   tempSync_q;
  // temperature word only taken once two synced samples agree
  logic [7:0]   tempStage_q;
  logic [7:0]   tempVal_q;
  logic [7:0]   tempVal_d;

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      stepMeta_q <= '0;
      stepSync_q <= '0;
      dirMeta_q  <= '0;
      dirSync_q  <= '0;
      tempMeta_q <= '0;
      tempSync_q <= '0;
      tempStage_q <= '0;
      tempVal_q  <= '0;
    end
    else
    begin
      stepMeta_q <= stepIn;
      stepSync_q <= stepMeta_q;
      dirMeta_q  <= dirIn;
      dirSync_q  <= dirMeta_q;
      tempMeta_q <= tempIn;
      tempSync_q <= tempMeta_q;
      tempStage_q <= tempSync_q;
      tempVal_q  <= tempVal_d;
    end
  end

  // per-axis edge detection and position
  logic [N-1:0] stepEvent;
  logic [W-1:0] position [N];

  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : gAxis
      ssd_axis #(
        .POS_W (W)
      ) uAxis (
        .core_clk  (core_clk),
        .reset     (reset),
        .stepSync  (stepSync_q[g]),
        .dirSync   (dirSync_q[g]),
        .stepEvent (stepEvent[g]),
        .position  (position[g])
      );
    end
  endgenerate

  // register state
  logic [7:0]  switch_q;
  logic [7:0]  switch_d;
  logic [7:0]  tLimit_q;
  logic [7:0]  tLimit_d;
  logic [31:0] idleCnt_q;
  logic [31:0] idleCnt_d;
  logic        reduced_q;
  logic        reduced_d;
  logic        hot_q;
  logic        hot_d;
  logic        ack_q;
  logic        ack_d;
  logic [31:0] rdat_q;
  logic [31:0] rdat_d;
  logic [N*4-1:0] div_q;
  logic [N*4-1:0] div_d;
  logic [5:0]  curC_q;
  logic [5:0]  curC_d;
  logic [5:0]  curXyz_q;
  logic [5:0]  curXyz_d;
  logic        auxPwm_q;
  logic        auxPwm_d;
  logic        auxBrake_q;
  logic        auxBrake_d;

  logic        busReq;
  logic [7:0]  limitWr;
  logic [7:0]  posOff;
  integer      i;

  // bus access, idle timer, temperature and switch decode
  always_comb
  begin
    busReq     = wb_cyc_i & wb_stb_i & ~ack_q;
    switch_d   = switch_q;
    tLimit_d   = tLimit_q;
    ack_d      = busReq;
    rdat_d     = rdat_q;
    idleCnt_d  = idleCnt_q;
    reduced_d  = reduced_q;
    limitWr    = tLimit_q;
    posOff     = 8'h00;
    // register write and read
    if (busReq && wb_we_i && wb_sel_i[0])
    begin
      if (wb_adr_i == ssd_pkg::REG_SWITCH)
        switch_d = wb_dat_i[7:0];
      else if (wb_adr_i == ssd_pkg::REG_TLIMIT)
      begin
        // limit is clamped into the allowed window
        limitWr = wb_dat_i[7:0];
        if (limitWr < ssd_pkg::TEMP_MIN_C)
          limitWr = ssd_pkg::TEMP_MIN_C;
        if (limitWr > ssd_pkg::TEMP_MAX_C)
          limitWr = ssd_pkg::TEMP_MAX_C;
        tLimit_d = limitWr;
      end
    end
    if (busReq && !wb_we_i)
    begin
      rdat_d = 32'h0000_0000;
      case (wb_adr_i)
        ssd_pkg::REG_SWITCH: rdat_d = {24'h00_0000, switch_q};
        ssd_pkg::REG_STATUS: rdat_d = {16'h0000, tempVal_q, 6'h00, hot_q, reduced_q};
        ssd_pkg::REG_TLIMIT: rdat_d = {24'h00_0000, tLimit_q};
        default:
        begin
          for (i = 0; i < N; i++)
          begin
            posOff = ssd_pkg::REG_POS0 + 8'(i * 4);
            if (wb_adr_i == posOff)
              rdat_d = position[i];
          end
        end
      endcase
    end
    // no step for the idle time drops the current
    if (|stepEvent)
    begin
      idleCnt_d = 32'h0000_0000;
      reduced_d = 1'b0;
    end
    else if (idleCnt_q >= 32'(IDLE_CYCLES - 1))
      reduced_d = 1'b1;
    else
      idleCnt_d = idleCnt_q + 32'h0000_0001;
    // a torn multi-bit sample never reaches the compare
    tempVal_d = (tempSync_q == tempStage_q) ? tempSync_q : tempVal_q;
    // over-temperature with one degree of hysteresis
    hot_d = hot_q;
    if (tempVal_q >= tLimit_q)
      hot_d = 1'b1;
    else if (tempVal_q < tLimit_q - 8'h01)
      hot_d = 1'b0;
    // switch bank decode
    for (i = 0; i < N; i++)
      div_d[i*4 +: 4] = switch_q[ssd_pkg::SW_RES_LSB + i] ? ssd_pkg::USTEP_COARSE
                                                          : ssd_pkg::USTEP_FINE;
    case (switch_q[ssd_pkg::SW_CCUR_LSB +: 2])
      2'h0:    curC_d = ssd_pkg::CUR_1A4;
      2'h1:    curC_d = ssd_pkg::CUR_2A0;
      2'h2:    curC_d = ssd_pkg::CUR_2A8;
      default: curC_d = ssd_pkg::CUR_3A5;
    endcase
    curXyz_d = switch_q[ssd_pkg::SW_XYZCUR_BIT] ? ssd_pkg::CUR_3A5
                                                : ssd_pkg::CUR_2A8;
    auxBrake_d = (switch_q[ssd_pkg::SW_AUX_BIT] == ssd_pkg::SSD_AUX_BRAKE);
    auxPwm_d   = ~auxBrake_d;
  end

  // registers
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      switch_q   <= ssd_pkg::SWITCH_RST;
      tLimit_q   <= ssd_pkg::TEMP_LIMIT_RST;
      idleCnt_q  <= 32'h0000_0000;
      reduced_q  <= 1'b0;
      hot_q      <= 1'b0;
      ack_q      <= 1'b0;
      rdat_q     <= 32'h0000_0000;
      div_q      <= {N{ssd_pkg::USTEP_FINE}};
      curC_q     <= ssd_pkg::CUR_1A4;
      curXyz_q   <= ssd_pkg::CUR_3A5;
      auxPwm_q   <= 1'b1;
      auxBrake_q <= 1'b0;
    end
    else
    begin
      switch_q   <= switch_d;
      tLimit_q   <= tLimit_d;
      idleCnt_q  <= idleCnt_d;
      reduced_q  <= reduced_d;
      hot_q      <= hot_d;
      ack_q      <= ack_d;
      rdat_q     <= rdat_d;
      div_q      <= div_d;
      curC_q     <= curC_d;
      curXyz_q   <= curXyz_d;
      auxPwm_q   <= auxPwm_d;
      auxBrake_q <= auxBrake_d;
    end
  end

  // outputs straight from flip-flops
  assign wb_ack_o       = ack_q;
  assign wb_dat_o       = rdat_q;
  assign ustepDiv       = div_q;
  assign currentC       = curC_q;
  assign currentXyz     = curXyz_q;
  assign currentReduced = reduced_q;
  assign auxPwmMode     = auxPwm_q;
  assign auxBrakeMode   = auxBrake_q;
  assign overTemp       = hot_q;
endmodule

// file: sim/ssd_top_monitor.sv
// bound checker on the ports of the step/direction front end
`timescale 1ns/1ns
module ssd_top_monitor #(
  parameter int unsigned IDLE_CYCLES = 50
) (
  input wire logic        core_clk,
  input wire logic        reset,
  input wire logic [3:0]  stepIn,
  input wire logic [7:0]  tempIn,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  input wire logic [15:0] ustepDiv,
  input wire logic [5:0]  currentC,
  input wire logic [5:0]  currentXyz,
  input wire logic        currentReduced,
  input wire logic        auxPwmMode,
  input wire logic        auxBrakeMode,
  input wire logic        overTemp
);
  localparam logic [5:0] CTAB [4] = '{ssd_pkg::CUR_1A4, ssd_pkg::CUR_2A0,
                                      ssd_pkg::CUR_2A8, ssd_pkg::CUR_3A5};
  logic        wrSw;
  logic [3:0]  step_q;
  logic [7:0]  sw_q;
  logic [7:0]  sw_d;
  logic [31:0] idle_q;
  logic [31:0] idle_d;
  function automatic logic [3:0] nib(input logic b);
    return b ? ssd_pkg::USTEP_COARSE : ssd_pkg::USTEP_FINE;
  endfunction
  // switch write taken at this edge
  assign wrSw = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0]
                & (wb_adr_i == ssd_pkg::REG_SWITCH);
  // last switch value, cycles since a rising step pin
  always_comb
  begin
    sw_d = wrSw ? wb_dat_i[7:0] : sw_q;
    idle_d = (idle_q > IDLE_CYCLES + 9) ? idle_q : idle_q + 32'h1;
    if (|(stepIn & ~step_q))
      idle_d = 32'h0;
  end
  always_ff @(posedge core_clk)
  begin
    step_q <= stepIn;
    sw_q   <= sw_d;
    idle_q <= reset ? 32'h0 : idle_d;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  ack_next_a:
  assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered next cycle");
  res_decode_a:
  assert property (wrSw |-> ##2 ustepDiv == {nib(sw_q[3]), nib(sw_q[2]),
                                             nib(sw_q[1]), nib(sw_q[0])})
    else $error("resolution outputs wrong");
  c_current_a:
  assert property (wrSw |-> ##2 currentC == CTAB[sw_q[5:4]])
    else $error("c current wrong");
  xyz_current_a:
  assert property (wrSw |-> ##2 currentXyz == (sw_q[6] ? ssd_pkg::CUR_3A5 : ssd_pkg::CUR_2A8))
    else $error("xyz current wrong");
  aux_mode_a:
  assert property (wrSw |-> ##2 auxBrakeMode == sw_q[7] && auxPwmMode == !sw_q[7])
    else $error("aux output role wrong");
  step_wake_a:
  assert property (currentReduced && |(stepIn & ~$past(stepIn)) |-> ##[1:6] !currentReduced)
    else $error("rising step did not end reduction");
  idle_delay_a:
  assert property ($rose(currentReduced) |-> idle_q + 1 >= IDLE_CYCLES
                                             && idle_q <= IDLE_CYCLES + 6)
    else $error("reduction delay out of range");
  hot_set_a:
  assert property ((tempIn >= ssd_pkg::TEMP_MAX_C) [*5] |=> overTemp)
    else $error("over temperature not flagged");
endmodule
bind ssd_top ssd_top_monitor #(.IDLE_CYCLES(IDLE_CYCLES)) i_mon (
  .core_clk(core_clk), .reset(reset), .stepIn(stepIn), .tempIn(tempIn),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .ustepDiv(ustepDiv),
  .currentC(currentC), .currentXyz(currentXyz), .currentReduced(currentReduced),
  .auxPwmMode(auxPwmMode), .auxBrakeMode(auxBrakeMode), .overTemp(overTemp));

// file: sim/ssd_step_host.sv
// host pulse generator on the step and direction pins
`timescale 1ns/1ns
module ssd_step_host (
  input  wire logic        core_clk,
  output logic [3:0]       stepIn,
  output logic [3:0]       dirIn
);
  // pins idle low
  initial
  begin
    stepIn = 4'h0;
    dirIn  = 4'h0;
  end
  // n pulses on one axis: 2 us high, 10 us period
  task automatic pulse(input int axis, input logic up, input int n);
    repeat (n)
    begin
      @(posedge core_clk);
      dirIn[axis] <= up;
      repeat (4) @(posedge core_clk);
      stepIn[axis] <= 1'b1;
      repeat (40) @(posedge core_clk);
      stepIn[axis] <= 1'b0;
      repeat (155) @(posedge core_clk);
    end
  endtask
endmodule

// file: sim/ssd_top_tb.sv
// self-checking bench for the step/direction front end
`timescale 1ns/1ns
module ssd_top_tb;
  localparam int unsigned IDLE = 50;
  localparam logic [5:0] CTAB [4] = '{6'h0e, 6'h14, 6'h1c, 6'h23};
  logic        core_clk, reset, cyc, stb, we, ack, red, pwm, brake, hot;
  logic [3:0]  stepIn, dirIn, sel;
  logic [7:0]  tempIn, adr;
  logic [31:0] wdat, rdat, rd;
  logic [15:0] ustepDiv;
  logic [5:0]  curC, curXyz;
  int          n_mismatch, checked;
  ssd_top #(.IDLE_CYCLES(IDLE)) i_dut (.core_clk(core_clk), .reset(reset),
    .stepIn(stepIn), .dirIn(dirIn), .tempIn(tempIn), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .ustepDiv(ustepDiv), .currentC(curC), .currentXyz(curXyz),
    .currentReduced(red), .auxPwmMode(pwm), .auxBrakeMode(brake), .overTemp(hot));
  ssd_step_host i_host (.core_clk(core_clk), .stepIn(stepIn), .dirIn(dirIn));
  // 20 MHz clock
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one classic wishbone cycle, read data left in rd
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, 4'hf};
    do
    begin
      @(posedge core_clk);
      t++;
    end
    while (ack !== 1'b1 && t < 20);
    if (t >= 20)
      check("ack", 32'h0, 32'h1);
    rd = rdat;
    {cyc, stb} <= 2'b00;
    @(posedge core_clk);
  endtask
  task automatic t_reset();
    check("ustepDiv", ustepDiv, 32'haaaa);
    check("currentC", curC, 32'h0e);
    check("currentXyz", curXyz, 32'h23);
    check("aux", {pwm, brake}, 32'h2);
    bus(1'b1, 8'h40, 32'hff);
    bus(1'b0, 8'h40, 32'h0);
    check("unmapped", rd, 32'h0);
  endtask
  task automatic t_switch();
    logic [7:0]  sw;
    logic [15:0] e;
    for (int i = 0; i < 4; i++)
    begin
      sw = {i[0], i[1], i[1:0], 4'h1 << i};
      e = 16'haaaa;
      e[4*i +: 4] = 4'h5;
      bus(1'b1, 8'h00, {24'h0, sw});
      check("ustepDiv", ustepDiv, e);
      check("currentC", curC, CTAB[i]);
      check("currentXyz", curXyz, i[1] ? 32'h23 : 32'h1c);
      check("aux", {pwm, brake}, i[0] ? 32'h1 : 32'h2);
      bus(1'b0, 8'h00, 32'h0);
      check("switch", rd, {24'h0, sw});
    end
  endtask
  task automatic t_steps();
    int pos [4] = '{3, -2, -1, 1};
    i_host.pulse(0, 1'b1, 3);
    i_host.pulse(1, 1'b0, 2);
    i_host.pulse(3, 1'b1, 1);
    check("reduced", red, 32'h1);
    fork
      i_host.pulse(2, 1'b0, 1);
      begin
        repeat (12) @(posedge core_clk);
        check("reduced", red, 32'h0);
        repeat (IDLE - 10) @(posedge core_clk);
        check("reduced", red, 32'h0);
        repeat (20) @(posedge core_clk);
        check("reduced", red, 32'h1);
      end
    join
    for (int k = 0; k < 4; k++)
    begin
      bus(1'b0, 8'h10 + 8'(4 * k), 32'h0);
      check("position", rd, pos[k]);
    end
  endtask
  task automatic temp_step(input logic [7:0] t, input logic e);
    tempIn <= t;
    repeat (6) @(posedge core_clk);
    check("overTemp", hot, e);
  endtask
  task automatic t_temp();
    temp_step(8'h4f, 1'b0);
    temp_step(8'h50, 1'b1);
    temp_step(8'h4f, 1'b1);
    temp_step(8'h4e, 1'b0);
    bus(1'b0, 8'h04, 32'h0);
    check("status", rd[15:1], {8'h4e, 7'h0});
    bus(1'b1, 8'h08, 32'h30);
    bus(1'b0, 8'h08, 32'h0);
    check("limit", rd, 32'h46);
    bus(1'b1, 8'h08, 32'hff);
    temp_step(8'h54, 1'b0);
    temp_step(8'h55, 1'b1);
    temp_step(8'h56, 1'b1);
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // main sequence
  initial
  begin
    {reset, cyc, stb, we, adr, sel, wdat, tempIn} = {1'b1, 3'b0, 8'h0, 4'h0, 32'h0, 8'h19};
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    t_reset();
    t_switch();
    t_steps();
    t_temp();
    final_report();
  end
  // watchdog
  initial
  begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    final_report();
  end
endmodule
